// *** acd_pkg.sv ***
// Constants and types for the addressing mode decoder
// Summary of operation
// - Inherent instructions are one byte, two with prefix 90; nothing is fetched after the opcode.
// - Inherent set: nop, trap, wait, halt, returns, mask, carry, stack reset; the decoder accepts every op up to 19 as inherent.
// - Immediate is two bytes and allowed only for load, compare, logic, arithmetic.
// - Immediate operand is the byte after the opcode; no memory read.
// - Direct operand address comes from the bytes after the opcode.
// - Short direct fetches one address byte; address within 00-FF.
// - Long direct fetches a two-byte address; reaches the whole 64K space.
// - Read-modify-write, bit, shift and swap ops have only short direct form.
// - Indexed address is unsigned sum of index register and offset.
// - Indexed without offset fetches nothing; address is index value in 00-FF.
// - Short indexed adds one offset byte to index; reaches up to 1FE.
// - Long indexed adds a two-byte offset to index; reaches 64K space.
// - Read-modify-write class has no long-offset indexed form.
// - Indirect: byte after opcode locates a pointer read before the operand.
// - Short indirect reads a byte pointer; address within 00-FF.
// - Long indirect forms take one pointer byte but read a word pointer.
// - Read-modify-write class uses plain indirect only with a byte pointer.
// - Indirect indexed address is index plus pointer read from memory.
// - Short indirect indexed reads a byte pointer; sum reaches up to 1FE.
// - Read-modify-write class uses indirect indexed only with a byte pointer.
// - Relative branches add a signed byte offset, direct or from memory.
// - Prefix 90 selects the second index register.
// - Prefix 92 turns direct into indirect and offset indexed into indirect indexed.
// - Prefix 91 turns first-index indirect indexed into second-index form.
package acd_pkg;
    localparam logic [7:0] SECOND_INDEX_PREFIX = 8'h90;
    localparam logic [7:0] INDIRECT_PREFIX = 8'h92;
    localparam logic [7:0] INDIRECT_SECOND_INDEX_PREFIX = 8'h91;
    // Opcode layout: mode field on top, operation below
    localparam int OPC_MODE_LSB = 5;
    localparam logic [2:0] MF_INHERENT = 3'h0;
    localparam logic [2:0] MF_IMMEDIATE = 3'h1;
    localparam logic [2:0] MF_DIR_SHORT = 3'h2;
    localparam logic [2:0] MF_DIR_LONG = 3'h3;
    localparam logic [2:0] MF_IDX_NONE = 3'h4;
    localparam logic [2:0] MF_IDX_SHORT = 3'h5;
    localparam logic [2:0] MF_IDX_LONG = 3'h6;
    localparam logic [2:0] MF_RELATIVE = 3'h7;
    // Operations 00..09 are the full class, 10..1f the read-modify-write class
    localparam logic [4:0] OP_FULL_LIMIT = 5'h0a;
    localparam logic [4:0] NOP_OP = 5'h00;
    localparam logic [4:0] TRAP_OP = 5'h01;
    localparam logic [4:0] WAIT_FOR_INTERRUPT_OP = 5'h02;
    localparam logic [4:0] HALT_OP = 5'h03;
    localparam logic [4:0] RETURN_OP = 5'h04;
    localparam logic [4:0] INTERRUPT_RETURN_OP = 5'h05;
    localparam logic [4:0] MASK_SET_OP = 5'h06;
    localparam logic [4:0] MASK_CLEAR_OP = 5'h07;
    localparam logic [4:0] CARRY_SET_OP = 5'h08;
    localparam logic [4:0] CARRY_CLEAR_OP = 5'h09;
    localparam logic [4:0] STACK_POINTER_RESET_OP = 5'h0a;
    localparam logic [4:0] INH_LAST_OP = 5'h19;
    localparam logic [15:0] SHORT_SPAN_MAX = 16'h00ff;
    localparam logic [15:0] SHORT_IDX_SPAN_MAX = 16'h01fe;
    typedef enum logic [1:0] {PK_NONE, PK_Y, PK_IND, PK_IND_Y} acd_pfx_t;
    typedef enum logic [3:0] {
        AM_INHERENT, AM_IMMEDIATE, AM_DIR_SHORT, AM_DIR_LONG,
        AM_IDX_NONE, AM_IDX_SHORT, AM_IDX_LONG, AM_IND_SHORT, AM_IND_LONG,
        AM_INDIDX_SHORT, AM_INDIDX_LONG, AM_REL_DIR, AM_REL_IND, AM_BAD
    } acd_mode_t;
    typedef enum {
        ST_IDLE, ST_OPC, ST_DECODE, ST_EXT1, ST_EXT2, ST_PTR_HI, ST_PTR_LO,
        ST_FINISH
    } acd_state_t;
endpackage : acd_pkg

// *** acd_decode_if.sv ***
// Decode request and classification result between core and classifier
`timescale 1ns/1ns
interface acd_decode_if;
    import acd_pkg::*;
    acd_pfx_t pfx;
    logic [7:0] opcode;
    acd_mode_t mode;
    logic use_y;
    logic [1:0] ext_bytes;
    logic ptr_read;
    logic ptr_word;
    logic rmw_op;
    logic long_form;
    logic illegal;
    modport classifier (
        input pfx, opcode,
        output mode, use_y, ext_bytes, ptr_read, ptr_word, rmw_op,
        output long_form, illegal
    );
    modport core (
        output pfx, opcode,
        input mode, use_y, ext_bytes, ptr_read, ptr_word, rmw_op,
        input long_form, illegal
    );
endinterface : acd_decode_if

// *** acd_mode_class.sv ***
// Combinational opcode and prefix classifier
`timescale 1ns/1ns
module acd_mode_class (
    // Decode request and result
    acd_decode_if.classifier dec
);
    import acd_pkg::*;

    wire [2:0] mfield = dec.opcode[7:OPC_MODE_LSB];
    wire [4:0] op = dec.opcode[4:0];
    wire full_op = op < OP_FULL_LIMIT;
    wire rmw = op[4];
    wire mem_ok = full_op | rmw;
    wire plain = (dec.pfx == PK_NONE) || (dec.pfx == PK_Y);
    wire to_ind = dec.pfx == PK_IND;
    wire to_indidx = (dec.pfx == PK_IND) || (dec.pfx == PK_IND_Y);

    acd_mode_t mode;
    logic [1:0] ext;
    logic ptr;
    logic ptrw;

    always_comb begin
        mode = AM_BAD;
        ext = 2'd0;
        ptr = 1'b0;
        ptrw = 1'b0;
        case (mfield)
            MF_INHERENT: begin
                if (plain && op <= INH_LAST_OP) mode = AM_INHERENT;
            end
            MF_IMMEDIATE: begin
                if (plain && full_op) begin
                    mode = AM_IMMEDIATE;
                    ext = 2'd1;
                end
            end
            MF_DIR_SHORT: begin
                if (mem_ok && plain) begin
                    mode = AM_DIR_SHORT;
                    ext = 2'd1;
                end else if (mem_ok && to_ind) begin
                    mode = AM_IND_SHORT;
                    ext = 2'd1;
                    ptr = 1'b1;
                end
            end
            MF_DIR_LONG: begin
                // Long forms carry the full class only
                if (full_op && plain) begin
                    mode = AM_DIR_LONG;
                    ext = 2'd2;
                end else if (full_op && to_ind) begin
                    mode = AM_IND_LONG;
                    ext = 2'd1;
                    ptr = 1'b1;
                    ptrw = 1'b1;
                end
            end
            MF_IDX_NONE: begin
                if (mem_ok && plain) mode = AM_IDX_NONE;
            end
            MF_IDX_SHORT: begin
                if (mem_ok && plain) begin
                    mode = AM_IDX_SHORT;
                    ext = 2'd1;
                end else if (mem_ok && to_indidx) begin
                    mode = AM_INDIDX_SHORT;
                    ext = 2'd1;
                    ptr = 1'b1;
                end
            end
            MF_IDX_LONG: begin
                if (full_op && plain) begin
                    mode = AM_IDX_LONG;
                    ext = 2'd2;
                end else if (full_op && to_indidx) begin
                    mode = AM_INDIDX_LONG;
                    ext = 2'd1;
                    ptr = 1'b1;
                    ptrw = 1'b1;
                end
            end
            MF_RELATIVE: begin
                if (dec.pfx == PK_NONE) begin
                    mode = AM_REL_DIR;
                    ext = 2'd1;
                end else if (to_ind) begin
                    mode = AM_REL_IND;
                    ext = 2'd1;
                    ptr = 1'b1;
                end
            end
            default: mode = AM_BAD;
        endcase
    end

    assign dec.mode = mode;
    assign dec.ext_bytes = ext;
    assign dec.ptr_read = ptr;
    assign dec.ptr_word = ptrw;
    assign dec.use_y = (dec.pfx == PK_Y) || (dec.pfx == PK_IND_Y);
    assign dec.rmw_op = rmw;
    assign dec.long_form = (mfield == MF_DIR_LONG) || (mfield == MF_IDX_LONG);
    assign dec.illegal = mode == AM_BAD;
endmodule : acd_mode_class

// *** cpu_addressing_mode_decoder.sv ***
// Instruction length and effective address engine of the 8-bit core
`timescale 1ns/1ns
module cpu_addressing_mode_decoder (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // Decode request
    input wire logic START,
    input wire logic [15:0] PC_IN,
    input wire logic [7:0] X_IN,
    input wire logic [7:0] Y_IN,
    // Memory read port
    output logic MEM_RD,
    output logic [15:0] MEM_ADDR,
    input wire logic [7:0] MEM_RDATA,
    input wire logic MEM_ACK,
    // Decode result
    output logic BUSY,
    output logic DONE,
    output logic ILLEGAL,
    output logic [3:0] MODE,
    output logic [4:0] OP,
    output logic USE_Y,
    output logic [2:0] LENGTH,
    output logic [15:0] EA,
    output logic [7:0] OPERAND,
    output logic [15:0] BRANCH_TARGET,
    output logic [15:0] NEXT_PC
);
    import acd_pkg::*;

    // Reset release through two flops
    logic rst_s1;
    logic rst_n;
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    acd_decode_if dec ();
    acd_mode_class u_class (
        .dec(dec.classifier)
    );

    acd_state_t st_q;
    acd_pfx_t pfx_q;
    logic [15:0] pc_q;
    logic [7:0] x_q;
    logic [7:0] y_q;
    logic [7:0] opc_q;
    logic [7:0] b1_q;
    logic [7:0] b2_q;
    logic [7:0] ptr_hi_q;
    logic [7:0] ptr_lo_q;
    logic [2:0] len_q;
    logic done_q;
    logic illegal_q;
    acd_mode_t mode_q;
    logic use_y_q;
    logic [15:0] ea_q;
    logic [7:0] operand_q;
    logic [15:0] target_q;
    logic [15:0] next_pc_q;
    logic [2:0] length_q;

    assign dec.pfx = pfx_q;
    assign dec.opcode = opc_q;

    // Fetch addressing
    wire in_ptr = (st_q == ST_PTR_HI) || (st_q == ST_PTR_LO);
    wire [7:0] ptr_addr = (st_q == ST_PTR_LO) ? b1_q + 8'h01 : b1_q;
    wire rd_req = (st_q == ST_OPC) || (st_q == ST_EXT1) ||
        (st_q == ST_EXT2) || in_ptr;
    wire fetch = rd_req && MEM_ACK;
    // Pointers always sit in page zero; word pointers wrap within it
    wire [15:0] rd_addr = in_ptr ? {8'h00, ptr_addr} : pc_q;
    wire [15:0] pc_inc = pc_q + 16'h0001;
    wire [2:0] len_inc = len_q + 3'd1;

    // Prefix recognition; a second prefix is taken as the opcode
    wire is_pfx_y = MEM_RDATA == SECOND_INDEX_PREFIX;
    wire is_pfx_ind = MEM_RDATA == INDIRECT_PREFIX;
    wire is_pfx_indy = MEM_RDATA == INDIRECT_SECOND_INDEX_PREFIX;
    wire take_pfx = (pfx_q == PK_NONE) &&
        (is_pfx_y || is_pfx_ind || is_pfx_indy);
    acd_pfx_t pfx_new;
    always_comb begin
        if (is_pfx_y) pfx_new = PK_Y;
        else if (is_pfx_ind) pfx_new = PK_IND;
        else pfx_new = PK_IND_Y;
    end

    // Address arithmetic
    wire [7:0] idx8 = dec.use_y ? y_q : x_q;
    wire [15:0] idx16 = {8'h00, idx8};
    wire [15:0] word_ext = {b1_q, b2_q};
    wire [15:0] word_ptr = {ptr_hi_q, ptr_lo_q};
    wire [7:0] rel_off = (dec.mode == AM_REL_IND) ? ptr_hi_q : b1_q;
    wire [15:0] rel_sext = {{8{rel_off[7]}}, rel_off};
    wire [15:0] target_d = pc_q + rel_sext;

    logic [15:0] ea_d;
    always_comb begin
        case (dec.mode)
            AM_DIR_SHORT: ea_d = {8'h00, b1_q};
            AM_DIR_LONG: ea_d = word_ext;
            AM_IDX_NONE: ea_d = idx16;
            AM_IDX_SHORT: ea_d = idx16 + {8'h00, b1_q};
            AM_IDX_LONG: ea_d = word_ext + idx16;
            AM_IND_SHORT: ea_d = {8'h00, ptr_hi_q};
            AM_IND_LONG: ea_d = word_ptr;
            AM_INDIDX_SHORT: ea_d = idx16 + {8'h00, ptr_hi_q};
            AM_INDIDX_LONG: ea_d = word_ptr + idx16;
            default: ea_d = 16'h0000;
        endcase
    end

    // Sequencer
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            pfx_q <= PK_NONE;
            pc_q <= 16'h0000;
            len_q <= 3'd0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (START) begin
                        st_q <= ST_OPC;
                        pfx_q <= PK_NONE;
                        pc_q <= PC_IN;
                        len_q <= 3'd0;
                    end
                end
                ST_OPC: begin
                    if (fetch) begin
                        pc_q <= pc_inc;
                        len_q <= len_inc;
                        if (take_pfx) pfx_q <= pfx_new;
                        else st_q <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    if (dec.illegal || dec.ext_bytes == 2'd0) begin
                        st_q <= ST_FINISH;
                    end else begin
                        st_q <= ST_EXT1;
                    end
                end
                ST_EXT1: begin
                    if (fetch) begin
                        pc_q <= pc_inc;
                        len_q <= len_inc;
                        if (dec.ext_bytes == 2'd2) st_q <= ST_EXT2;
                        else if (dec.ptr_read) st_q <= ST_PTR_HI;
                        else st_q <= ST_FINISH;
                    end
                end
                ST_EXT2: begin
                    if (fetch) begin
                        pc_q <= pc_inc;
                        len_q <= len_inc;
                        st_q <= ST_FINISH;
                    end
                end
                ST_PTR_HI: begin
                    if (fetch) begin
                        st_q <= dec.ptr_word ? ST_PTR_LO : ST_FINISH;
                    end
                end
                ST_PTR_LO: begin
                    if (fetch) st_q <= ST_FINISH;
                end
                ST_FINISH: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Fetched bytes; held until overwritten by the next instruction
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            x_q <= 8'h00;
            y_q <= 8'h00;
            opc_q <= 8'h00;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            ptr_hi_q <= 8'h00;
            ptr_lo_q <= 8'h00;
        end else begin
            if (st_q == ST_IDLE && START) begin
                x_q <= X_IN;
                y_q <= Y_IN;
            end
            if (st_q == ST_OPC && fetch && !take_pfx) opc_q <= MEM_RDATA;
            if (st_q == ST_EXT1 && fetch) b1_q <= MEM_RDATA;
            if (st_q == ST_EXT2 && fetch) b2_q <= MEM_RDATA;
            if (st_q == ST_PTR_HI && fetch) ptr_hi_q <= MEM_RDATA;
            if (st_q == ST_PTR_LO && fetch) ptr_lo_q <= MEM_RDATA;
        end
    end

    // Result registers, loaded once per instruction
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            illegal_q <= 1'b0;
            mode_q <= AM_INHERENT;
            use_y_q <= 1'b0;
            ea_q <= 16'h0000;
            operand_q <= 8'h00;
            target_q <= 16'h0000;
            next_pc_q <= 16'h0000;
            length_q <= 3'd0;
        end else begin
            done_q <= st_q == ST_FINISH;
            if (st_q == ST_FINISH) begin
                illegal_q <= dec.illegal;
                mode_q <= dec.mode;
                use_y_q <= dec.use_y;
                ea_q <= ea_d;
                operand_q <= b1_q;
                target_q <= target_d;
                next_pc_q <= pc_q;
                length_q <= len_q;
            end
        end
    end

    assign MEM_RD = rd_req;
    assign MEM_ADDR = rd_addr;
    assign BUSY = st_q != ST_IDLE;
    assign DONE = done_q;
    assign ILLEGAL = illegal_q;
    assign MODE = mode_q;
    assign OP = opc_q[4:0];
    assign USE_Y = use_y_q;
    assign LENGTH = length_q;
    assign EA = ea_q;
    assign OPERAND = operand_q;
    assign BRANCH_TARGET = target_q;
    assign NEXT_PC = next_pc_q;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!rst_n);

    AST_INH_ONE_BYTE: assert property (
        DONE && mode_q == AM_INHERENT |->
            LENGTH == ((pfx_q == PK_NONE) ? 3'd1 : 3'd2))
        else $error("inherent length wrong");
    AST_IMM_OPERAND: assert property (
        DONE && mode_q == AM_IMMEDIATE |->
            OPERAND == b1_q && NEXT_PC == $past(pc_q))
        else $error("immediate operand wrong");
    AST_SHORT_DIR_PAGE: assert property (
        DONE && mode_q == AM_DIR_SHORT |-> EA <= SHORT_SPAN_MAX)
        else $error("short direct left page zero");
    AST_LONG_DIR_ORDER: assert property (
        DONE && mode_q == AM_DIR_LONG |-> EA == {b1_q, b2_q})
        else $error("long address byte order wrong");
    AST_LONG_RMW_REFUSED: assert property (
        st_q == ST_DECODE && dec.rmw_op && dec.long_form |->
            ##2 (DONE && ILLEGAL))
        else $error("long form accepted for rmw class");
    AST_SHORT_IDX_SPAN: assert property (
        DONE && (mode_q == AM_IDX_SHORT || mode_q == AM_INDIDX_SHORT) |->
            EA <= SHORT_IDX_SPAN_MAX)
        else $error("short indexed span exceeded");
    AST_PTR_PAGE_ZERO: assert property (
        MEM_RD && in_ptr |-> MEM_ADDR[15:8] == 8'h00)
        else $error("pointer read outside page zero");
    AST_IND_SHORT_PAGE: assert property (
        DONE && mode_q == AM_IND_SHORT |-> EA == {8'h00, ptr_hi_q})
        else $error("short indirect address wrong");
    AST_REL_TARGET: assert property (
        DONE && mode_q == AM_REL_DIR |->
            BRANCH_TARGET == NEXT_PC + {{8{b1_q[7]}}, b1_q})
        else $error("relative target wrong");
    AST_PFX_SECOND_INDEX: assert property (
        st_q == ST_OPC && fetch && pfx_q == PK_NONE && is_pfx_y |=>
            pfx_q == PK_Y && st_q == ST_OPC)
        else $error("second index prefix not taken");
    AST_REQ_HELD: assert property (
        MEM_RD && !MEM_ACK |=> MEM_RD && $stable(MEM_ADDR))
        else $error("read request dropped before ack");
    AST_NO_EXT_FETCH: assert property (
        st_q == ST_DECODE && dec.ext_bytes == 2'd0 |=>
            st_q == ST_FINISH && !MEM_RD)
        else $error("byte fetched after a bare opcode");
    AST_IMM_NO_READ: assert property (
        st_q == ST_EXT1 && fetch && dec.mode == AM_IMMEDIATE |=>
            st_q == ST_FINISH && !MEM_RD)
        else $error("memory read after immediate operand");
    AST_WORD_PTR_NEXT: assert property (
        MEM_RD && st_q == ST_PTR_LO |-> MEM_ADDR[7:0] == b1_q + 8'h01)
        else $error("word pointer low byte address wrong");
    AST_INDIDX_SUM: assert property (
        DONE && mode_q == AM_INDIDX_LONG |->
            EA == {ptr_hi_q, ptr_lo_q} + {8'h00, (USE_Y ? y_q : x_q)})
        else $error("indirect indexed sum wrong");
endmodule : cpu_addressing_mode_decoder

// *** acd_mem_model.sv ***
// Program and data memory model answering the decoder's read port
`timescale 1ns/1ns
module acd_mem_model (
    // Clock
    input wire logic clk,
    // Read port
    input wire logic rd,
    input wire logic [15:0] addr,
    output logic [7:0] rdata,
    output logic ack,
    // Wait states before each ack
    input wire logic [3:0] wait_n
);
    logic [7:0] m [0:65535];
    logic [3:0] cnt_q = 4'h0;
    logic [7:0] last_q = 8'h00;
    assign ack = rd && (cnt_q >= wait_n);
    // Stale data is inverted so a late sample never looks right
    assign rdata = ack ? m[addr] : ~last_q;
    always_ff @(posedge clk) begin
        if (ack) begin
            cnt_q <= 4'h0;
            last_q <= rdata;
        end else if (rd) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : acd_mem_model

// *** cpu_addressing_mode_decoder_tb.sv ***
// Self-checking bench of the addressing mode decoder
`timescale 1ns/1ns
module cpu_addressing_mode_decoder_tb;
    import acd_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic [15:0] pc_in = 16'h0200;
    logic [7:0] x_in = 8'h00;
    logic [7:0] y_in = 8'h00;
    logic [3:0] mem_wait = 4'h0;
    logic mem_rd, mem_ack, busy, done, illegal, use_y;
    logic [15:0] mem_addr, ea, target, next_pc;
    logic [7:0] mem_rdata, operand;
    logic [3:0] mode;
    logic [4:0] op;
    logic [2:0] length;
    int n_errors = 0;
    int total_checks = 0;
    int n_reads = 0;

    cpu_addressing_mode_decoder DUT (
        .CLK_SYS(clk), .RST_B(rst_b), .START(start), .PC_IN(pc_in),
        .X_IN(x_in), .Y_IN(y_in), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr),
        .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .BUSY(busy),
        .DONE(done), .ILLEGAL(illegal), .MODE(mode), .OP(op),
        .USE_Y(use_y), .LENGTH(length), .EA(ea), .OPERAND(operand),
        .BRANCH_TARGET(target), .NEXT_PC(next_pc)
    );
    acd_mem_model mem (
        .clk(clk), .rd(mem_rd), .addr(mem_addr), .rdata(mem_rdata),
        .ack(mem_ack), .wait_n(mem_wait)
    );

    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (mem_rd && mem_ack) begin
            n_reads++;
        end
    end

    task automatic end_of_test();
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            n_errors++;
        end
    endtask : chk

    // Instruction bytes always start at 0200
    task automatic prog(input logic [31:0] b);
        for (int k = 0; k < 4; k++) begin
            mem.m[16'h0200 + 16'(k)] = b[31 - 8 * k -: 8];
        end
    endtask : prog

    task automatic run(input logic [7:0] x, y);
        @(negedge clk);
        start = 1'b1;
        x_in = x;
        y_in = y;
        n_reads = 0;
        @(negedge clk);
        start = 1'b0;
        chk("busy", 16'(busy), 16'h1);
        for (int i = 0; i < 200 && done !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (done !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
    endtask : run

    task automatic res(input acd_mode_t md, input logic [2:0] len,
        input logic [15:0] e, input int rd);
        chk("mode", 16'(mode), 16'(md));
        chk("length", 16'(length), 16'(len));
        chk("ea", ea, e);
        chk("reads", 16'(n_reads), 16'(rd));
        chk("next_pc", next_pc, 16'h0200 + 16'(len));
        chk("illegal", 16'(illegal), 16'h0);
        chk("busy", 16'(busy), 16'h0);
    endtask : res

    // Refused form: flagged, and fetching stops after the opcode
    task automatic bad(input int rd);
        chk("illegal", 16'(illegal), 16'h1);
        chk("reads", 16'(n_reads), 16'(rd));
    endtask : bad

    task automatic t_inh();
        for (int i = 0; i <= 10; i++) begin
            prog({8'(i), 24'h0});
            run(8'h00, 8'h00);
            res(AM_INHERENT, 3'h1, 16'h0, 1);
            chk("op", 16'(op), 16'(i));
        end
        prog(32'h90080000);
        run(8'h00, 8'h00);
        res(AM_INHERENT, 3'h2, 16'h0, 2);
        chk("use_y", 16'(use_y), 16'h1);
    endtask : t_inh

    task automatic t_imm();
        for (int i = 0; i < 10; i++) begin
            prog({8'h20 | 8'(i), 8'h5a, 16'h0});
            run(8'h00, 8'h00);
            res(AM_IMMEDIATE, 3'h2, 16'h0, 2);
            chk("operand", 16'(operand), 16'h005a);
        end
        prog(32'h30000000);
        run(8'h00, 8'h00);
        bad(1);
    endtask : t_imm

    task automatic t_dir();
        mem_wait = 4'h2;
        prog(32'h42a50000);
        run(8'h00, 8'h00);
        res(AM_DIR_SHORT, 3'h2, 16'h00a5, 2);
        prog(32'h52a50000);
        run(8'h00, 8'h00);
        res(AM_DIR_SHORT, 3'h2, 16'h00a5, 2);
        prog(32'h61123400);
        run(8'h00, 8'h00);
        res(AM_DIR_LONG, 3'h3, 16'h1234, 3);
        prog(32'h71123400);
        run(8'h00, 8'h00);
        bad(1);
        mem_wait = 4'h0;
    endtask : t_dir

    task automatic t_idx();
        prog(32'h80000000);
        run(8'hc3, 8'h3c);
        res(AM_IDX_NONE, 3'h1, 16'h00c3, 1);
        prog(32'h90800000);
        run(8'hc3, 8'h3c);
        res(AM_IDX_NONE, 3'h2, 16'h003c, 2);
        prog(32'ha1ff0000);
        run(8'hff, 8'h00);
        res(AM_IDX_SHORT, 3'h2, 16'h01fe, 2);
        prog(32'hb1ff0000);
        run(8'hff, 8'h00);
        res(AM_IDX_SHORT, 3'h2, 16'h01fe, 2);
        prog(32'hc1123400);
        run(8'h80, 8'h00);
        res(AM_IDX_LONG, 3'h3, 16'h12b4, 3);
        prog(32'hd1123400);
        run(8'h80, 8'h00);
        bad(1);
    endtask : t_idx

    task automatic t_ind();
        mem.m[16'h0040] = 8'h77;
        mem.m[16'h00ff] = 8'hab;
        mem.m[16'h0000] = 8'hcd;
        prog(32'h92424000);
        run(8'h00, 8'h00);
        res(AM_IND_SHORT, 3'h3, 16'h0077, 4);
        prog(32'h92524000);
        run(8'h00, 8'h00);
        res(AM_IND_SHORT, 3'h3, 16'h0077, 4);
        mem_wait = 4'h1;
        prog(32'h9262ff00);
        run(8'h00, 8'h00);
        res(AM_IND_LONG, 3'h3, 16'habcd, 5);
        mem_wait = 4'h0;
        prog(32'h9272ff00);
        run(8'h00, 8'h00);
        bad(2);
    endtask : t_ind

    task automatic t_indidx();
        mem.m[16'h0040] = 8'hff;
        mem.m[16'h0050] = 8'h12;
        mem.m[16'h0051] = 8'h34;
        prog(32'h92a14000);
        run(8'hff, 8'h01);
        res(AM_INDIDX_SHORT, 3'h3, 16'h01fe, 4);
        prog(32'h91a14000);
        run(8'hff, 8'h01);
        res(AM_INDIDX_SHORT, 3'h3, 16'h0100, 4);
        chk("use_y", 16'(use_y), 16'h1);
        prog(32'h92c15000);
        run(8'h80, 8'h00);
        res(AM_INDIDX_LONG, 3'h3, 16'h12b4, 5);
        prog(32'h92d15000);
        run(8'h80, 8'h00);
        bad(2);
    endtask : t_indidx

    task automatic t_rel();
        prog(32'he0800000);
        run(8'h00, 8'h00);
        res(AM_REL_DIR, 3'h2, 16'h0, 2);
        chk("target", target, 16'h0182);
        mem.m[16'h0040] = 8'h05;
        prog(32'h92e04000);
        run(8'h00, 8'h00);
        res(AM_REL_IND, 3'h3, 16'h0, 4);
        chk("target", target, 16'h0208);
    endtask : t_rel

    // Second index register, refused opcodes 2a and 1a, and forms that a prefix may not reach
    task automatic t_pfx();
        prog(32'h9042a500);
        run(8'h00, 8'h20);
        res(AM_DIR_SHORT, 3'h3, 16'h00a5, 3);
        chk("use_y", 16'(use_y), 16'h1);
        prog(32'h90a11000);
        run(8'h00, 8'h20);
        res(AM_IDX_SHORT, 3'h3, 16'h0030, 3);
        prog(32'h91c15000);
        run(8'h80, 8'h01);
        res(AM_INDIDX_LONG, 3'h3, 16'h1235, 5);
        prog(32'h2a000000);
        run(8'h00, 8'h00);
        bad(1);
        prog(32'h1a000000);
        run(8'h00, 8'h00);
        bad(1);
        prog(32'h92800000);
        run(8'h00, 8'h00);
        bad(2);
        prog(32'h90e00000);
        run(8'h00, 8'h00);
        bad(2);
    endtask : t_pfx

    // Start ignored while busy; reset in mid-fetch clears the results
    task automatic t_rst();
        mem_wait = 4'h8;
        prog(32'h09000000);
        @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        pc_in = 16'h0300;
        @(negedge clk);
        start = 1'b0;
        pc_in = 16'h0200;
        chk("busy", 16'(busy), 16'h1);
        chk("mem_addr", mem_addr, 16'h0200);
        rst_b = 1'b0;
        @(negedge clk);
        chk("busy", 16'(busy), 16'h0);
        chk("mem_rd", 16'(mem_rd), 16'h0);
        chk("mem_addr", mem_addr, 16'h0000);
        chk("done", 16'(done), 16'h0);
        chk("mode", 16'(mode), 16'h0);
        chk("length", 16'(length), 16'h0);
        chk("next_pc", next_pc, 16'h0000);
        rst_b = 1'b1;
        mem_wait = 4'h0;
        repeat (3) @(negedge clk);
        run(8'h00, 8'h00);
        res(AM_INHERENT, 3'h1, 16'h0, 1);
    endtask : t_rst

    initial begin
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        t_inh();
        t_imm();
        t_dir();
        t_idx();
        t_ind();
        t_indidx();
        t_rel();
        t_pfx();
        t_rst();
        end_of_test();
    end
endmodule : cpu_addressing_mode_decoder_tb
